// *** bench/ort_config_bank_asserts.sv ***
// Port checker for the output-two configuration bank.
// Assumes a bind onto ort_config_bank from the testbench top.
`timescale 1ns/10ps

module ort_config_bank_asserts (
  input wire       clock,
  input wire       nrst,
  input wire [7:0] reg_addr,
  input wire       reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire       reg_rd_en,
  input wire [7:0] reg_rd_data_reg,
  input wire       reg_rd_valid_reg,
  input wire       reg_rd_hit_reg,
  input wire [2:0] out_two_source_select,
  input wire [2:0] out_two_routing_select,
  input wire [2:0] positive_leg_gain_level,
  input wire       driver_enable_reg,
  input wire       dac_to_positive_reg,
  input wire       dac_to_negative_reg,
  input wire       bypass_to_positive_reg,
  input wire       bypass_to_negative_reg,
  input wire [7:0] positive_leg_gain_db_reg
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Antecedents on $past(nrst) skip the first edge after release
  a_read_valid: assert property ($past(nrst) |->
    reg_rd_valid_reg == $past(reg_rd_en)) else $error("read valid misplaced");
  a_unmapped_read: assert property (reg_rd_en && reg_addr != 8'h6b && reg_addr != 8'h6c
    |=> reg_rd_data_reg == 8'h00 && !reg_rd_hit_reg) else $error("unmapped read not empty");
  a_mapped_hit: assert property (reg_rd_en && reg_addr == 8'h6c |=> reg_rd_hit_reg &&
    reg_rd_data_reg[5:3] == $past(positive_leg_gain_level)) else $error("bad read of 6c");
  a_source_write: assert property (reg_wr_en && reg_addr == 8'h6b |=>
    out_two_source_select == $past(reg_wr_data[7:5]) &&
    out_two_routing_select == $past(reg_wr_data[4:2])) else $error("6b fields wrong");
  a_level_hold: assert property (!(reg_wr_en && reg_addr == 8'h6c) |=>
    $stable(positive_leg_gain_level)) else $error("level changed without write");
  a_driver_enable: assert property ($past(nrst) |-> driver_enable_reg ==
    ($past(out_two_source_select) inside {[3'h1:3'h5]})) else $error("driver enable wrong");
  a_split_route: assert property (out_two_source_select == 3'h4 |=>
    dac_to_positive_reg && bypass_to_negative_reg && !dac_to_negative_reg &&
    !bypass_to_positive_reg) else $error("split route wrong");
  a_gain_top: assert property (positive_leg_gain_level == 3'h0 |=>
    positive_leg_gain_db_reg == 8'h18) else $error("top gain wrong");
endmodule // ort_config_bank_asserts

// *** bench/test_output_two_route_config.sv ***
// Self-checking bench for the output-two configuration bank.
// Assumes the bank's byte strobes are driven on rising clock edges.
`timescale 1ns/10ps

module test_output_two_route_config;
  reg        clock;
  reg        nrst;
  reg  [7:0] addr;
  reg        wr_en;
  reg  [7:0] wr_data;
  reg        rd_en;
  wire [7:0] rd_data, gain_db;
  wire [2:0] src, route, level;
  wire [1:0] drive;
  wire       rd_valid, rd_hit, common_mode_level, lp, imp, topo, bw, drv_en, dac_p, dac_n;
  wire       byp_p, byp_n, p_cm, n_cm, src_rsv, rt_rsv, lvl_rsv;
  integer    n_mismatch, compares, cycles;

  ort_config_bank dut_u (
    .clock(clock), .nrst(nrst), .reg_addr(addr), .reg_wr_en(wr_en),
    .reg_wr_data(wr_data), .reg_rd_en(rd_en), .reg_rd_data_reg(rd_data),
    .reg_rd_valid_reg(rd_valid), .reg_rd_hit_reg(rd_hit), .out_two_source_select(src),
    .out_two_routing_select(route), .out_two_common_mode_select(common_mode_level),
    .out_two_low_power(lp), .positive_leg_drive_type(drive),
    .positive_leg_gain_level(level), .negative_bypass_impedance(imp),
    .bypass_input_topology(topo), .dac_two_bandwidth(bw), .driver_enable_reg(drv_en),
    .dac_to_positive_reg(dac_p), .dac_to_negative_reg(dac_n),
    .bypass_to_positive_reg(byp_p), .bypass_to_negative_reg(byp_n),
    .positive_pin_common_reg(p_cm), .negative_pin_common_reg(n_cm),
    .positive_leg_gain_db_reg(gain_db), .source_reserved_reg(src_rsv),
    .routing_reserved_reg(rt_rsv), .level_reserved_reg(lvl_rsv));

  // Clock, 10 ns period
  always #5 clock = ~clock;

  // Hang guard: the whole run needs about 130 cycles
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end

  // Value comparison; a one-bit flag arrives zero-extended
  task cmp(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Write, then wait one more edge so the decoded controls have landed
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      @(posedge clock);
      #1;
    end
  endtask

  // Read; valid stands one cycle only, so it is looked at right away
  task rd(input [7:0] a, input [7:0] exp, input hit);
    begin
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      cmp(rd_valid, 8'h01);
      cmp(rd_data, exp);
      cmp(rd_hit, hit);
    end
  endtask

  // Reset for eight cycles, then both bytes must read their reset values
  task t_reset;
    begin
      nrst <= 1'b0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      rd(8'h6b, 8'h20, 1'b1);
      rd(8'h6c, 8'h20, 1'b1);
      cmp(drv_en, 8'h01);
      cmp(gain_db, 8'h00);
    end
  endtask

  // Every source code with differential routing left at zero
  task t_sources;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        wr(8'h6b, {i[2:0], 5'h00});
        cmp(src, i[2:0]);
        cmp(drv_en, i >= 1 && i <= 5);
        cmp(src_rsv, i >= 6);
        cmp(dac_p, i == 1 || i == 3 || i == 4);
        cmp(dac_n, i == 1 || i == 3 || i == 5);
        cmp(byp_p, i == 2 || i == 3 || i == 5);
        cmp(byp_n, i == 2 || i == 3 || i == 4);
      end
    end
  endtask

  // Every routing code with the DAC source; low power only when differential
  task t_routes;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        wr(8'h6b, {3'h1, i[2:0], i[0], i == 0});
        cmp(route, i[2:0]);
        cmp(common_mode_level, i[0]);
        cmp(lp, i == 0);
        cmp(dac_p, i <= 2 || i == 4);
        cmp(dac_n, i <= 1 || i == 3 || i == 6);
        cmp(n_cm, i == 4);
        cmp(p_cm, i == 6);
        cmp(rt_rsv, i == 5 || i == 7);
      end
    end
  endtask

  // Drive, level and low bits of the second byte, read back each time
  task t_levels;
    integer i;
    reg [2:0] lo;
    reg [63:0] tbl;
    begin
      // DAC source with stereo single-ended routing, so the top gain code is legal
      wr(8'h6b, 8'h24);
      tbl = {8'h00, 8'hf4, 8'hfa, 8'h00, 8'h06, 8'h0c, 8'h12, 8'h18};
      for (i = 0; i < 8; i = i + 1) begin
        lo = (i == 6) ? 3'h3 : i[2:0];
        wr(8'h6c, {i[1:0], i[2:0], lo});
        cmp(level, i[2:0]);
        cmp(drive, i[1:0]);
        cmp({imp, topo, bw}, lo);
        cmp(gain_db, tbl[i*8 +: 8]);
        cmp(lvl_rsv, i == 7);
        rd(8'h6c, {i[1:0], i[2:0], lo}, 1'b1);
      end
    end
  endtask

  // Neighbour addresses take no write; 6d reads as empty
  task t_unmapped;
    begin
      wr(8'h6a, 8'h00);
      wr(8'h6d, 8'h00);
      rd(8'h6d, 8'h00, 1'b0);
      rd(8'h6b, 8'h24, 1'b1);
      rd(8'h6c, 8'hff, 1'b1);
    end
  endtask

  // Verdict and end of run
  task stop_test;
    begin
      if (n_mismatch == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // Main sequence, ending with a mid-run reset
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    addr = 8'h00;
    wr_en = 1'b0;
    wr_data = 8'h00;
    rd_en = 1'b0;
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    t_reset;
    t_sources;
    t_routes;
    t_levels;
    t_unmapped;
    // Mid-run reset is asserted on a rising edge like every other input
    @(posedge clock);
    t_reset;
    stop_test;
  end
endmodule // test_output_two_route_config

bind ort_config_bank ort_config_bank_asserts chk_u (
  .clock, .nrst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data_reg,
  .reg_rd_valid_reg, .reg_rd_hit_reg, .out_two_source_select, .out_two_routing_select,
  .positive_leg_gain_level, .driver_enable_reg, .dac_to_positive_reg, .dac_to_negative_reg,
  .bypass_to_positive_reg, .bypass_to_negative_reg, .positive_leg_gain_db_reg);

// *** design/ort_byte_reg.v ***
// One read/write configuration byte with a parameterised reset value.
// Assumes the write strobe is already decoded and synchronous to clock.
`timescale 1ns/10ps

module ort_byte_reg #(
  parameter [7:0] RESET_VALUE = 8'h00
) (
  input  wire       clock,
  input  wire       nrst,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  output reg  [7:0] q_reg
);

  // Stores every written value, reserved codes included, so reads match writes
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q_reg <= RESET_VALUE;
    end else if (wr_en) begin
      q_reg <= wr_data;
    end
  end

endmodule // ort_byte_reg

// *** design/ort_config_bank.v ***
// Configuration bank for the second analog output channel: two bytes that
// steer source, routing, common mode, drive, gain and bypass settings.
// Assumes the control interface hands over decoded byte accesses in the
// clock domain; analog blocks sample the control outputs as levels.
`timescale 1ns/10ps
`include "ort_defs.vh"

module ort_config_bank (
  input  wire       clock,
  input  wire       nrst,
  // Byte access from the control interface
  input  wire [7:0] reg_addr,
  input  wire       reg_wr_en,
  input  wire [7:0] reg_wr_data,
  input  wire       reg_rd_en,
  output reg  [7:0] reg_rd_data_reg,
  output reg        reg_rd_valid_reg,
  output reg        reg_rd_hit_reg,
  // Raw fields
  output wire [2:0] out_two_source_select,
  output wire [2:0] out_two_routing_select,
  output wire       out_two_common_mode_select,
  output wire       out_two_low_power,
  output wire [1:0] positive_leg_drive_type,
  output wire [2:0] positive_leg_gain_level,
  output wire       negative_bypass_impedance,
  output wire       bypass_input_topology,
  output wire       dac_two_bandwidth,
  // Decoded analog controls
  output reg        driver_enable_reg,
  output reg        dac_to_positive_reg,
  output reg        dac_to_negative_reg,
  output reg        bypass_to_positive_reg,
  output reg        bypass_to_negative_reg,
  output reg        positive_pin_common_reg,
  output reg        negative_pin_common_reg,
  output reg  [7:0] positive_leg_gain_db_reg,
  output reg        source_reserved_reg,
  output reg        routing_reserved_reg,
  output reg        level_reserved_reg
);

  wire [7:0] src_route_q;
  wire [7:0] drive_byp_q;
  wire       hit_src_route;
  wire       hit_drive_byp;

  // Address decode; unmapped writes are dropped, unmapped reads give zero
  assign hit_src_route = (reg_addr == `ORT_ADDR_SRC_ROUTE);
  assign hit_drive_byp = (reg_addr == `ORT_ADDR_DRIVE_BYP);

  // First byte: source, routing, common mode, low power
  ort_byte_reg #(
    .RESET_VALUE (`ORT_RST_SRC_ROUTE)
  ) u_src_route (
    .clock   (clock),
    .nrst    (nrst),
    .wr_en   (reg_wr_en & hit_src_route),
    .wr_data (reg_wr_data),
    .q_reg   (src_route_q)
  );

  // Second byte: drive, level, impedance, bypass topology, bandwidth
  ort_byte_reg #(
    .RESET_VALUE (`ORT_RST_DRIVE_BYP)
  ) u_drive_byp (
    .clock   (clock),
    .nrst    (nrst),
    .wr_en   (reg_wr_en & hit_drive_byp),
    .wr_data (reg_wr_data),
    .q_reg   (drive_byp_q)
  );

  // Field taps straight from the stored bytes, so they follow every write
  assign out_two_source_select      = src_route_q[`ORT_SRC_MSB:`ORT_SRC_LSB];
  assign out_two_routing_select     = src_route_q[`ORT_ROUTE_MSB:`ORT_ROUTE_LSB];
  assign out_two_common_mode_select = src_route_q[`ORT_COMMON_MODE_LEVEL_BIT];
  // Stored as written; the host keeps it to the DAC, non-stereo case
  assign out_two_low_power          = src_route_q[`ORT_LP_BIT];
  assign positive_leg_drive_type    = drive_byp_q[`ORT_DRIVE_MSB:`ORT_DRIVE_LSB];
  assign positive_leg_gain_level    = drive_byp_q[`ORT_LVL_MSB:`ORT_LVL_LSB];
  assign negative_bypass_impedance  = drive_byp_q[`ORT_IMP_BIT];
  assign bypass_input_topology      = drive_byp_q[`ORT_BYPCFG_BIT];
  assign dac_two_bandwidth          = drive_byp_q[`ORT_BW_BIT];

  // Read port: data registered one cycle after the strobe
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rd_data_reg  <= `ORT_RD_UNMAPPED;
      reg_rd_valid_reg <= 1'b0;
      reg_rd_hit_reg   <= 1'b0;
    end else begin
      reg_rd_valid_reg <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_hit_reg <= hit_src_route | hit_drive_byp;
        if (hit_src_route) begin
          reg_rd_data_reg <= src_route_q;
        end else if (hit_drive_byp) begin
          reg_rd_data_reg <= drive_byp_q;
        end else begin
          reg_rd_data_reg <= `ORT_RD_UNMAPPED;
        end
      end
    end
  end

  reg       src_dac_next;
  reg       src_byp_next;
  reg       src_res_next;
  reg       pos_active_next;
  reg       neg_active_next;
  reg       pos_cm_next;
  reg       neg_cm_next;
  reg       rt_res_next;
  reg [7:0] gain_db_next;
  reg       lvl_res_next;

  // Source decode; reserved codes leave the driver off rather than guess a path
  always @* begin
    src_dac_next = 1'b0;
    src_byp_next = 1'b0;
    src_res_next = 1'b0;
    case (out_two_source_select)
      `ORT_SRC_OFF:         src_res_next = 1'b0;
      `ORT_SRC_DAC:         src_dac_next = 1'b1;
      `ORT_SRC_BYP:         src_byp_next = 1'b1;
      `ORT_SRC_BOTH: begin
        src_dac_next = 1'b1;
        src_byp_next = 1'b1;
      end
      `ORT_SRC_DAC_P_BYP_M: src_res_next = 1'b0;
      `ORT_SRC_BYP_P_DAC_M: src_res_next = 1'b0;
      default:              src_res_next = 1'b1;
    endcase
  end

  // Routing decode: which pins carry signal and which sit at common mode
  always @* begin
    pos_active_next = 1'b0;
    neg_active_next = 1'b0;
    pos_cm_next     = 1'b0;
    neg_cm_next     = 1'b0;
    rt_res_next     = 1'b0;
    case (out_two_routing_select)
      `ORT_RT_DIFF, `ORT_RT_STEREO_SE: begin
        pos_active_next = 1'b1;
        neg_active_next = 1'b1;
      end
      `ORT_RT_MONO_P:      pos_active_next = 1'b1;
      `ORT_RT_MONO_M:      neg_active_next = 1'b1;
      `ORT_RT_PSEUDO_M_CM: begin
        pos_active_next = 1'b1;
        neg_cm_next     = 1'b1;
      end
      `ORT_RT_PSEUDO_P_CM: begin
        neg_active_next = 1'b1;
        pos_cm_next     = 1'b1;
      end
      default:             rt_res_next = 1'b1;
    endcase
  end

  // Gain decode; code 6 is decoded too, its use is the host's responsibility
  always @* begin
    lvl_res_next = 1'b0;
    case (positive_leg_gain_level)
      `ORT_LVL_P24: gain_db_next = `ORT_DB_P24;
      `ORT_LVL_P18: gain_db_next = `ORT_DB_P18;
      `ORT_LVL_P12: gain_db_next = `ORT_DB_P12;
      `ORT_LVL_P6:  gain_db_next = `ORT_DB_P6;
      `ORT_LVL_0:   gain_db_next = `ORT_DB_0;
      `ORT_LVL_M6:  gain_db_next = `ORT_DB_M6;
      `ORT_LVL_M12: gain_db_next = `ORT_DB_M12;
      default: begin
        gain_db_next = `ORT_DB_0;
        lvl_res_next = 1'b1;
      end
    endcase
  end

  wire src_dual_p = (out_two_source_select == `ORT_SRC_DAC_P_BYP_M);
  wire src_dual_m = (out_two_source_select == `ORT_SRC_BYP_P_DAC_M);
  // Dual-path codes override the routing field, which the host leaves alone then
  wire shared_src = src_dac_next | src_byp_next;

  // Registered analog controls; they trail the stored fields by one clock
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      driver_enable_reg        <= 1'b0;
      dac_to_positive_reg      <= 1'b0;
      dac_to_negative_reg      <= 1'b0;
      bypass_to_positive_reg   <= 1'b0;
      bypass_to_negative_reg   <= 1'b0;
      positive_pin_common_reg  <= 1'b0;
      negative_pin_common_reg  <= 1'b0;
      positive_leg_gain_db_reg <= `ORT_DB_0;
      source_reserved_reg      <= 1'b0;
      routing_reserved_reg     <= 1'b0;
      level_reserved_reg       <= 1'b0;
    end else begin
      driver_enable_reg        <= shared_src | src_dual_p | src_dual_m;
      dac_to_positive_reg      <= (src_dac_next & pos_active_next) | src_dual_p;
      dac_to_negative_reg      <= (src_dac_next & neg_active_next) | src_dual_m;
      bypass_to_positive_reg   <= (src_byp_next & pos_active_next) | src_dual_m;
      bypass_to_negative_reg   <= (src_byp_next & neg_active_next) | src_dual_p;
      positive_pin_common_reg  <= shared_src & pos_cm_next;
      negative_pin_common_reg  <= shared_src & neg_cm_next;
      positive_leg_gain_db_reg <= gain_db_next;
      source_reserved_reg      <= src_res_next;
      routing_reserved_reg     <= rt_res_next;
      level_reserved_reg       <= lvl_res_next;
    end
  end

endmodule // ort_config_bank

// *** design/ort_defs.vh ***
// Constants for the second analog output configuration bank: addresses,
// reset values, field positions and field codes.
// Assumes inclusion by bare name from the design files only.
`ifndef ORT_DEFS_VH
`define ORT_DEFS_VH

// Register addresses on the control interface
`define ORT_ADDR_SRC_ROUTE   8'h6b
`define ORT_ADDR_DRIVE_BYP   8'h6c

// Reset values
`define ORT_RST_SRC_ROUTE    8'h20
`define ORT_RST_DRIVE_BYP    8'h20
`define ORT_RD_UNMAPPED      8'h00

// First register field positions
`define ORT_SRC_MSB          7
`define ORT_SRC_LSB          5
`define ORT_ROUTE_MSB        4
`define ORT_ROUTE_LSB        2
`define ORT_COMMON_MODE_LEVEL_BIT         1
`define ORT_LP_BIT           0

// Second register field positions
`define ORT_DRIVE_MSB        7
`define ORT_DRIVE_LSB        6
`define ORT_LVL_MSB          5
`define ORT_LVL_LSB          3
`define ORT_IMP_BIT          2
`define ORT_BYPCFG_BIT       1
`define ORT_BW_BIT           0

// Source select codes
`define ORT_SRC_OFF          3'h0
`define ORT_SRC_DAC          3'h1
`define ORT_SRC_BYP          3'h2
`define ORT_SRC_BOTH         3'h3
`define ORT_SRC_DAC_P_BYP_M  3'h4
`define ORT_SRC_BYP_P_DAC_M  3'h5

// Routing codes
`define ORT_RT_DIFF          3'h0
`define ORT_RT_STEREO_SE     3'h1
`define ORT_RT_MONO_P        3'h2
`define ORT_RT_MONO_M        3'h3
`define ORT_RT_PSEUDO_M_CM   3'h4
`define ORT_RT_PSEUDO_P_CM   3'h6

// Level codes and their gain in dB, two's complement
`define ORT_LVL_P24          3'h0
`define ORT_LVL_P18          3'h1
`define ORT_LVL_P12          3'h2
`define ORT_LVL_P6           3'h3
`define ORT_LVL_0            3'h4
`define ORT_LVL_M6           3'h5
`define ORT_LVL_M12          3'h6
`define ORT_DB_P24           8'h18
`define ORT_DB_P18           8'h12
`define ORT_DB_P12           8'h0c
`define ORT_DB_P6            8'h06
`define ORT_DB_0             8'h00
`define ORT_DB_M6            8'hfa
`define ORT_DB_M12           8'hf4

`endif
